// *** src/data_transfer_insn_decoder.sv ***
`timescale 1ns/1ps
`default_nettype none
module data_transfer_insn_decoder (
   input  wire logic                        i_sys_clk,
   input  wire logic                        i_resetn,
   input  wire logic                        i_insn_valid,
   input  wire logic [xfer_pkg::INSN_W-1:0] i_insn,
   input  wire logic [xfer_pkg::DATA_W-1:0] i_insn_pc,
   output var  logic                        o_insn_ready,
   input  wire logic                        i_fetch_busy,
   output var  logic                        o_mem_req,
   output var  logic                        o_mem_we,
   output var  logic [1:0]                  o_mem_size,
   output var  logic [xfer_pkg::DATA_W-1:0] o_mem_addr,
   output var  logic [xfer_pkg::DATA_W-1:0] o_mem_wdata,
   input  wire logic                        i_mem_ack,
   input  wire logic [xfer_pkg::DATA_W-1:0] i_mem_rdata,
   input  wire logic [xfer_pkg::DATA_W-1:0] i_status_word,
   output var  logic [xfer_pkg::DATA_W-1:0] o_status_word,
   output var  logic                        o_flag_write,
   output var  logic                        o_priv_required,
   output var  logic                        o_retire,
   output var  logic                        o_illegal
);
   import xfer_pkg::*;

   // ****************************************
   // Declarations
   // ****************************************
   xfer_rf_if                rf ();
   dec_t                     head_dec;
   logic [REG_COUNT-1:0]     head_mask;
   logic [INSN_W-1:0]        slot0_insn_q, slot0_insn_d, slot1_insn_q, slot1_insn_d;
   logic [DATA_W-1:0]        slot0_pc_q, slot0_pc_d, slot1_pc_q, slot1_pc_d;
   logic [1:0]               cnt_q, cnt_d, cnt_pop;
   logic                     ready_q, ready_d;
   logic                     e_valid_q, e_valid_d;
   dec_t                     e_dec_q, e_dec_d;
   logic [DATA_W-1:0]        e_pc_q, e_pc_d;
   logic                     mem_req_q, mem_req_d, mem_we_q, mem_we_d;
   logic [1:0]               mem_size_q, mem_size_d;
   logic [DATA_W-1:0]        mem_addr_q, mem_addr_d, mem_wdata_q, mem_wdata_d;
   logic                     load_pend_q, load_pend_d;
   logic [REG_IDX_W-1:0]     load_dst_q, load_dst_d;
   logic [1:0]               load_size_q, load_size_d;
   logic                     retire_q, retire_d, illegal_q, illegal_d;
   logic [DATA_W-1:0]        status_q;
   logic                     head_valid, push, pop, issue, drop, hazard;
   logic                     e_mem, mem_free, e_done, load_back;
   logic [DATA_W-1:0]        base_val, data_val, zero_val, e_addr;

   xfer_field_decode u_decode (
      .i_insn     (slot0_insn_q),
      .o_dec      (head_dec),
      .o_use_mask (head_mask)
   );

   xfer_reg_store #(
      .NREGS (REG_COUNT)
   ) u_regs (
      .i_sys_clk (i_sys_clk),
      .i_resetn  (i_resetn),
      .rf        (rf.store)
   );

   // ****************************************
   // Issue control
   // ****************************************
   assign head_valid = (cnt_q != 2'h0);
   assign push       = i_insn_valid && ready_q;
   assign e_mem      = e_valid_q && ((e_dec_q.op == OP_LOAD) || (e_dec_q.op == OP_STORE));
   // One access in flight; next may leave on the ack
   assign mem_free   = (!mem_req_q || i_mem_ack) && (!load_pend_q || i_mem_ack);
   assign e_done     = e_valid_q && (!e_mem || (!i_fetch_busy && mem_free));
   assign load_back  = load_pend_q && i_mem_ack;
   assign hazard     = (load_pend_q && !i_mem_ack && head_mask[load_dst_q])
                     || (e_valid_q && (e_dec_q.op == OP_LOAD)
                         && head_mask[e_dec_q.dst_reg]);
   assign drop       = head_valid && (head_dec.op == OP_NONE);
   assign issue      = head_valid && !drop && !hazard && (!e_valid_q || e_done);
   assign pop        = issue || drop;

   // ****************************************
   // Instruction slots
   // ****************************************
   // Two slots let the registered ready keep one instruction per cycle
   always_comb begin
      slot0_insn_d = slot0_insn_q;
      slot0_pc_d   = slot0_pc_q;
      slot1_insn_d = slot1_insn_q;
      slot1_pc_d   = slot1_pc_q;
      cnt_pop      = cnt_q - {1'b0, pop};
      if (pop) begin
         slot0_insn_d = slot1_insn_q;
         slot0_pc_d   = slot1_pc_q;
      end
      if (push && (cnt_pop == 2'h0)) begin
         slot0_insn_d = i_insn;
         slot0_pc_d   = i_insn_pc;
      end else if (push) begin
         slot1_insn_d = i_insn;
         slot1_pc_d   = i_insn_pc;
      end
      cnt_d     = cnt_pop + {1'b0, push};
      ready_d   = (cnt_d < 2'h2);
      illegal_d = drop;
   end

   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         slot0_insn_q <= RST_INSN;
         slot1_insn_q <= RST_INSN;
         slot0_pc_q   <= RST_WORD;
         slot1_pc_q   <= RST_WORD;
         cnt_q        <= 2'h0;
         ready_q      <= 1'b0;
         illegal_q    <= 1'b0;
      end else begin
         slot0_insn_q <= slot0_insn_d;
         slot1_insn_q <= slot1_insn_d;
         slot0_pc_q   <= slot0_pc_d;
         slot1_pc_q   <= slot1_pc_d;
         cnt_q        <= cnt_d;
         ready_q      <= ready_d;
         illegal_q    <= illegal_d;
      end
   end

   // ****************************************
   // Execute stage and register writes
   // ****************************************
   // A stalled stage re-reads its own operands so they stay current
   always_comb begin
      rf.rd_addr[0] = issue ? head_dec.base_reg : e_dec_q.base_reg;
      rf.rd_addr[1] = issue ? head_dec.data_reg : e_dec_q.data_reg;
      rf.rd_addr[2] = REG_ZERO;
   end
   assign base_val = rf.rd_data[0];
   assign data_val = rf.rd_data[1];
   assign zero_val = rf.rd_data[2];

   always_comb begin
      case (e_dec_q.am)
         AM_PREDEC: e_addr = base_val - size_bytes(e_dec_q.size);
         AM_DISP:   e_addr = base_val + scale_disp(e_dec_q.lit, e_dec_q.size);
         AM_IDX:    e_addr = zero_val + base_val;
         AM_PC:     e_addr = e_pc_q + scale_disp(e_dec_q.lit, e_dec_q.size);
         default:   e_addr = base_val;
      endcase
   end

   always_comb begin
      e_valid_d = e_valid_q && !e_done;
      e_dec_d   = e_dec_q;
      e_pc_d    = e_pc_q;
      retire_d  = e_done;
      if (issue) begin
         e_valid_d = 1'b1;
         e_dec_d   = head_dec;
         e_pc_d    = slot0_pc_q;
      end
      // Port 0: execute results and address updates
      rf.wr_en[0]   = 1'b0;
      rf.wr_addr[0] = e_dec_q.dst_reg;
      rf.wr_data[0] = data_val;
      if (e_done) begin
         case (e_dec_q.op)
            OP_IMM: begin
               rf.wr_en[0]   = 1'b1;
               rf.wr_data[0] = sign_ext({24'h0, e_dec_q.lit}, SZ_BYTE);
            end
            OP_MOVE: rf.wr_en[0] = 1'b1;
            default: begin
               rf.wr_addr[0] = e_dec_q.base_reg;
               if (e_dec_q.am == AM_PREDEC) begin
                  rf.wr_en[0]   = 1'b1;
                  rf.wr_data[0] = e_addr;
               end else if (e_dec_q.am == AM_POSTINC) begin
                  rf.wr_en[0]   = 1'b1;
                  rf.wr_data[0] = base_val + size_bytes(e_dec_q.size);
               end
            end
         endcase
      end
      // Port 1: load data; it wins over port 0 on the same register
      rf.wr_en[1]   = load_back;
      rf.wr_addr[1] = load_dst_q;
      rf.wr_data[1] = sign_ext(i_mem_rdata, load_size_q);
   end

   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         e_valid_q <= 1'b0;
         e_dec_q   <= '0;
         e_pc_q    <= RST_WORD;
         retire_q  <= 1'b0;
      end else begin
         e_valid_q <= e_valid_d;
         e_dec_q   <= e_dec_d;
         e_pc_q    <= e_pc_d;
         retire_q  <= retire_d;
      end
   end

   // ****************************************
   // Memory access
   // ****************************************
   always_comb begin
      mem_req_d   = mem_req_q && !i_mem_ack;
      mem_we_d    = mem_we_q;
      mem_size_d  = mem_size_q;
      mem_addr_d  = mem_addr_q;
      mem_wdata_d = mem_wdata_q;
      load_pend_d = load_pend_q && !i_mem_ack;
      load_dst_d  = load_dst_q;
      load_size_d = load_size_q;
      if (e_done && e_mem) begin
         mem_req_d   = 1'b1;
         mem_we_d    = (e_dec_q.op == OP_STORE);
         mem_size_d  = e_dec_q.size;
         mem_addr_d  = e_addr;
         mem_wdata_d = data_val;
         load_pend_d = (e_dec_q.op == OP_LOAD);
         load_dst_d  = e_dec_q.dst_reg;
         load_size_d = e_dec_q.size;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         mem_req_q   <= 1'b0;
         mem_we_q    <= 1'b0;
         mem_size_q  <= SZ_BYTE;
         mem_addr_q  <= RST_WORD;
         mem_wdata_q <= RST_WORD;
         load_pend_q <= 1'b0;
         load_dst_q  <= REG_ZERO;
         load_size_q <= SZ_BYTE;
      end else begin
         mem_req_q   <= mem_req_d;
         mem_we_q    <= mem_we_d;
         mem_size_q  <= mem_size_d;
         mem_addr_q  <= mem_addr_d;
         mem_wdata_q <= mem_wdata_d;
         load_pend_q <= load_pend_d;
         load_dst_q  <= load_dst_d;
         load_size_q <= load_size_d;
      end
   end

   // ****************************************
   // Status word
   // ****************************************
   // No transfer writes the flag
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         status_q <= RST_WORD;
      end else begin
         status_q <= i_status_word;
      end
   end

   assign o_insn_ready    = ready_q;
   assign o_mem_req       = mem_req_q;
   assign o_mem_we        = mem_we_q;
   assign o_mem_size      = mem_size_q;
   assign o_mem_addr      = mem_addr_q;
   assign o_mem_wdata     = mem_wdata_q;
   assign o_status_word   = status_q;
   assign o_flag_write    = 1'b0;
   assign o_priv_required = 1'b0;
   assign o_retire        = retire_q;
   assign o_illegal       = illegal_q;
endmodule : data_transfer_insn_decoder
`default_nettype wire

// *** src/xfer_pkg.sv ***
`default_nettype none
// Notes on behaviour
// - Four-bit fields select registers; 0000 is zero.
// - Displacement scaled by 1, 2 or 4.
// - One execute cycle without wait states.
// - Fetch contention for memory adds cycles.
// - Stall users of a pending load target.
// - Transfers never touch the condition flag.
// - Transfers need no privileged mode.
// - Literal sign-extended into destination register.
// - Counter-relative word load, disp times two.
// - Counter-relative long load, disp times four.
// - Indirect stores by size; register copy.
// - Pre-decrement by size, then store.
// - Post-increment loads, extend, advance source.
// - Long post-increment: no extension, plus four.
// - Byte/word displacement stores of register zero.
// - Long displacement store, disp times four.
// - Byte/word displacement loads into register zero.
// - Long displacement load into any register.
// - Indexed byte store at zero plus destination.
package xfer_pkg;
   localparam int unsigned DATA_W    = 32;
   localparam int unsigned INSN_W    = 16;
   localparam int unsigned REG_IDX_W = 4;
   localparam int unsigned REG_COUNT = 16;
   localparam int unsigned RD_PORTS  = 3;
   localparam int unsigned WR_PORTS  = 2;
   // ****************************************
   // Instruction fields
   // ****************************************
   localparam int unsigned OPC_POS = 12;
   localparam int unsigned DST_POS = 8;
   localparam int unsigned SRC_POS = 4;
   localparam int unsigned SUB_POS = 0;
   localparam logic [3:0] REG_ZERO = 4'h0;
   localparam logic [3:0] OPC_IDX  = 4'h0;
   localparam logic [3:0] OPC_STD  = 4'h1;
   localparam logic [3:0] OPC_STR  = 4'h2;
   localparam logic [3:0] OPC_LDD  = 4'h5;
   localparam logic [3:0] OPC_LDR  = 4'h6;
   localparam logic [3:0] OPC_DSP8 = 4'h8;
   localparam logic [3:0] OPC_PCW  = 4'h9;
   localparam logic [3:0] OPC_PCL  = 4'hD;
   localparam logic [3:0] OPC_IMM  = 4'hE;
   localparam logic [3:0] SUB_MOVE = 4'h3;
   localparam logic [3:0] SUB_IDXB = 4'h4;
   localparam logic [3:0] DSP_STB  = 4'h0;
   localparam logic [3:0] DSP_STW  = 4'h1;
   localparam logic [3:0] DSP_LDB  = 4'h4;
   localparam logic [3:0] DSP_LDW  = 4'h5;
   localparam logic [1:0] SZ_BYTE  = 2'h0;
   localparam logic [1:0] SZ_WORD  = 2'h1;
   localparam logic [1:0] SZ_LONG  = 2'h2;
   localparam logic [1:0] SZ_NONE  = 2'h3;
   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [DATA_W-1:0] RST_WORD = 32'h0;
   localparam logic [INSN_W-1:0] RST_INSN = 16'h0;
   typedef enum logic [2:0] {OP_NONE, OP_IMM, OP_MOVE, OP_LOAD, OP_STORE} op_t;
   typedef enum logic [2:0] {AM_REG, AM_IND, AM_PREDEC, AM_POSTINC, AM_DISP, AM_IDX,
                             AM_PC} am_t;
   typedef struct packed {
      op_t            op;
      am_t            am;
      logic [1:0]     size;
      logic [3:0]     dst_reg;
      logic [3:0]     base_reg;
      logic [3:0]     data_reg;
      logic [7:0]     lit;
   } dec_t;
   function automatic logic [DATA_W-1:0] size_bytes(input logic [1:0] size);
      size_bytes = 32'h1 << size;
   endfunction : size_bytes
   function automatic logic [DATA_W-1:0] scale_disp(input logic [7:0] disp,
                                                    input logic [1:0] size);
      scale_disp = {24'h0, disp} << size;
   endfunction : scale_disp
   function automatic logic [DATA_W-1:0] sign_ext(input logic [DATA_W-1:0] v,
                                                  input logic [1:0] size);
      case (size)
         SZ_BYTE: sign_ext = {{24{v[7]}}, v[7:0]};
         SZ_WORD: sign_ext = {{16{v[15]}}, v[15:0]};
         default: sign_ext = v;
      endcase
   endfunction : sign_ext
endpackage : xfer_pkg
`default_nettype wire

// *** src/xfer_rf_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface xfer_rf_if;
   import xfer_pkg::*;
   logic [REG_IDX_W-1:0] rd_addr [RD_PORTS];
   logic [DATA_W-1:0]    rd_data [RD_PORTS];
   logic                 wr_en   [WR_PORTS];
   logic [REG_IDX_W-1:0] wr_addr [WR_PORTS];
   logic [DATA_W-1:0]    wr_data [WR_PORTS];
   modport core  (output rd_addr, input rd_data, output wr_en, output wr_addr,
                  output wr_data);
   modport store (input rd_addr, output rd_data, input wr_en, input wr_addr,
                  input wr_data);
endinterface : xfer_rf_if
`default_nettype wire

// *** src/xfer_reg_store.sv ***
`timescale 1ns/1ps
`default_nettype none
module xfer_reg_store #(
   parameter int unsigned NREGS = xfer_pkg::REG_COUNT
) (
   input  wire logic i_sys_clk,
   input  wire logic i_resetn,
   xfer_rf_if.store  rf
);
   import xfer_pkg::*;
   if (NREGS != (1 << REG_IDX_W)) begin : g_chk
      $error("xfer_reg_store: NREGS must match the register field width");
   end
   logic [DATA_W-1:0] mem_q  [NREGS];
   logic [DATA_W-1:0] rd_d   [RD_PORTS];
   logic [DATA_W-1:0] rd_q   [RD_PORTS];
   // Write-first bypass: no stale reads
   always_comb begin
      for (int p = 0; p < RD_PORTS; p++) begin
         rd_d[p] = mem_q[rf.rd_addr[p]];
         for (int w = 0; w < WR_PORTS; w++) begin
            if (rf.wr_en[w] && (rf.wr_addr[w] == rf.rd_addr[p])) begin
               rd_d[p] = rf.wr_data[w];
            end
         end
      end
   end
   always_ff @(posedge i_sys_clk) begin
      for (int w = 0; w < WR_PORTS; w++) begin
         if (rf.wr_en[w]) begin
            mem_q[rf.wr_addr[w]] <= rf.wr_data[w];
         end
      end
   end
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         for (int p = 0; p < RD_PORTS; p++) begin
            rd_q[p] <= RST_WORD;
         end
      end else begin
         rd_q <= rd_d;
      end
   end
   always_comb begin
      rf.rd_data = rd_q;
   end
endmodule : xfer_reg_store
`default_nettype wire

// *** src/xfer_field_decode.sv ***
`timescale 1ns/1ps
`default_nettype none
module xfer_field_decode (
   input  wire logic [xfer_pkg::INSN_W-1:0]    i_insn,
   output var  xfer_pkg::dec_t                 o_dec,
   output var  logic [xfer_pkg::REG_COUNT-1:0] o_use_mask
);
   import xfer_pkg::*;
   logic [3:0] opc;
   logic [3:0] dst_reg_field;
   logic [3:0] source_reg_field;
   logic [3:0] sub;
   logic       sz_ok;
   dec_t       d;
   always_comb begin
      opc              = i_insn[OPC_POS +: 4];
      dst_reg_field    = i_insn[DST_POS +: 4];
      source_reg_field = i_insn[SRC_POS +: 4];
      sub              = i_insn[SUB_POS +: 4];
      sz_ok            = !sub[3] && (sub[1:0] != SZ_NONE);
      d                = '0;
      d.lit            = i_insn[7:0];
      case (opc)
         OPC_IMM: begin
            d.op = OP_IMM;
            d.dst_reg = dst_reg_field;
         end
         OPC_PCW, OPC_PCL: begin
            d.op = OP_LOAD;
            d.am = AM_PC;
            d.dst_reg = dst_reg_field;
            d.size = (opc == OPC_PCW) ? SZ_WORD : SZ_LONG;
         end
         OPC_STD, OPC_LDD: begin
            d.op = (opc == OPC_STD) ? OP_STORE : OP_LOAD;
            d.am = AM_DISP;
            d.size = SZ_LONG;
            d.base_reg = (opc == OPC_STD) ? dst_reg_field : source_reg_field;
            d.data_reg = source_reg_field;
            d.dst_reg = dst_reg_field;
            d.lit = {4'h0, sub};
         end
         OPC_STR: begin
            if (sz_ok) begin
               d.op = OP_STORE;
               d.am = sub[2] ? AM_PREDEC : AM_IND;
               d.size = sub[1:0];
               d.base_reg = dst_reg_field;
               d.data_reg = source_reg_field;
            end
         end
         OPC_LDR: begin
            if (sub == SUB_MOVE) begin
               d.op = OP_MOVE;
               d.dst_reg = dst_reg_field;
               d.data_reg = source_reg_field;
            end else if (sz_ok) begin
               d.op = OP_LOAD;
               d.am = sub[2] ? AM_POSTINC : AM_IND;
               d.size = sub[1:0];
               d.base_reg = source_reg_field;
               d.dst_reg = dst_reg_field;
            end
         end
         OPC_IDX: begin
            if (sub == SUB_IDXB) begin
               d.op = OP_STORE;
               d.am = AM_IDX;
               d.size = SZ_BYTE;
               d.base_reg = dst_reg_field;
               d.data_reg = source_reg_field;
            end
         end
         OPC_DSP8: begin
            // Register in bits 7:4, displacement in 3:0
            d.am = AM_DISP;
            d.base_reg = source_reg_field;
            d.data_reg = REG_ZERO;
            d.dst_reg = REG_ZERO;
            d.size = {1'b0, dst_reg_field[0]};
            d.lit = {4'h0, sub};
            case (dst_reg_field)
               DSP_STB, DSP_STW: d.op = OP_STORE;
               DSP_LDB, DSP_LDW: d.op = OP_LOAD;
               default: d.op = OP_NONE;
            endcase
         end
         default: d.op = OP_NONE;
      endcase
      o_use_mask = '0;
      if ((d.op != OP_NONE) && (d.am != AM_REG) && (d.am != AM_PC)) begin
         o_use_mask[d.base_reg] = 1'b1;
      end
      if ((d.op == OP_STORE) || (d.op == OP_MOVE)) begin
         o_use_mask[d.data_reg] = 1'b1;
      end
      if ((d.op == OP_STORE) && (d.am == AM_IDX)) begin
         o_use_mask[REG_ZERO] = 1'b1;
      end
      if ((d.op == OP_LOAD) || (d.op == OP_MOVE) || (d.op == OP_IMM)) begin
         o_use_mask[d.dst_reg] = 1'b1;
      end
      o_dec = d;
   end
endmodule : xfer_field_decode
`default_nettype wire

// *** verification/xfer_mem_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module xfer_mem_model (
   input  wire logic        i_sys_clk,
   input  wire logic        i_resetn,
   input  wire logic        i_req,
   input  wire logic [31:0] i_addr,
   input  wire logic [3:0]  i_wait,
   output var  logic        o_ack,
   output var  logic [31:0] o_rdata
);
   logic [3:0]  cnt_q;
   logic [31:0] noise_q;
   assign o_ack = i_req && (cnt_q == i_wait);
   // Junk off ack: stale data never matches
   assign o_rdata = o_ack ? ~i_addr : noise_q;
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         cnt_q   <= 4'h0;
         noise_q <= 32'h0;
      end else begin
         cnt_q   <= (i_req && !o_ack) ? cnt_q + 4'h1 : 4'h0;
         noise_q <= noise_q + 32'h9E37_79B9;
      end
   end
endmodule : xfer_mem_model
`default_nettype wire

// *** verification/data_transfer_insn_decoder_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module data_transfer_insn_decoder_chk (
   input wire logic        i_sys_clk,
   input wire logic        i_resetn,
   input wire logic        i_insn_valid,
   input wire logic        o_insn_ready,
   input wire logic        i_fetch_busy,
   input wire logic        o_mem_req,
   input wire logic        o_mem_we,
   input wire logic [1:0]  o_mem_size,
   input wire logic [31:0] o_mem_addr,
   input wire logic [31:0] o_mem_wdata,
   input wire logic        i_mem_ack,
   input wire logic [31:0] i_status_word,
   input wire logic [31:0] o_status_word,
   input wire logic        o_flag_write,
   input wire logic        o_priv_required,
   input wire logic        o_retire,
   input wire logic        o_illegal
);
   import xfer_pkg::*;
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_resetn);
   AST_READY_AFTER_RST: assert property ($rose(i_resetn) |-> ##1 o_insn_ready)
      else $error("no ready");
   AST_RETIRE_BOUND: assert property (i_insn_valid && o_insn_ready |-> ##[2:40] (o_retire || o_illegal))
      else $error("no retire");
   AST_FETCH_FIRST: assert property ($rose(o_mem_req) |-> !$past(i_fetch_busy))
      else $error("access during fetch");
   AST_REQ_HOLD: assert property (o_mem_req && !i_mem_ack |=> o_mem_req
      && $stable({o_mem_addr, o_mem_wdata, o_mem_size, o_mem_we}))
      else $error("request moved");
   AST_SIZE_CODE: assert property (o_mem_req |-> o_mem_size != SZ_NONE)
      else $error("no size");
   AST_FLAG_KEPT: assert property ($past(i_resetn) |-> o_status_word == $past(i_status_word))
      else $error("status changed");
   AST_NO_FLAG_WR: assert property (!o_flag_write)
      else $error("flag write");
   AST_NO_PRIV: assert property (!o_priv_required)
      else $error("privilege");
   cover property (o_mem_req && o_mem_we && i_mem_ack);
   cover property (o_mem_req && !o_mem_we && !i_mem_ack);
   cover property (o_illegal);
endmodule : data_transfer_insn_decoder_chk
`default_nettype wire

// *** verification/data_transfer_insn_decoder_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module data_transfer_insn_decoder_tb;
   import xfer_pkg::*;
   logic        i_sys_clk = 1'h0, i_resetn = 1'h0, i_insn_valid = 1'h0, i_fetch_busy = 1'h0;
   logic [15:0] i_insn = 16'h0;
   logic [31:0] i_insn_pc = 32'h0, i_status_word = 32'hF1;
   logic [3:0]  wait_n = 4'h0;
   logic        o_insn_ready, o_mem_req, o_mem_we, i_mem_ack, o_flag_write;
   logic        o_priv_required, o_retire, o_illegal, cw;
   logic [1:0]  o_mem_size, cs;
   logic [31:0] o_mem_addr, o_mem_wdata, i_mem_rdata, o_status_word, ca, cd;
   int          errors = 0, n_tests = 0, n_ack = 0, n_ret = 0, n_ill = 0;
   always #25 i_sys_clk = ~i_sys_clk;
   data_transfer_insn_decoder data_transfer_insn_decoder_i (.i_sys_clk, .i_resetn,
      .i_insn_valid, .i_insn, .i_insn_pc, .o_insn_ready, .i_fetch_busy, .o_mem_req,
      .o_mem_we, .o_mem_size, .o_mem_addr, .o_mem_wdata, .i_mem_ack, .i_mem_rdata,
      .i_status_word, .o_status_word, .o_flag_write, .o_priv_required, .o_retire,
      .o_illegal);
   xfer_mem_model xfer_mem_model_i (.i_sys_clk, .i_resetn, .i_req(o_mem_req),
      .i_addr(o_mem_addr), .i_wait(wait_n), .o_ack(i_mem_ack), .o_rdata(i_mem_rdata));
   always @(negedge i_sys_clk) begin
      if (o_mem_req && i_mem_ack) begin
         {cw, cs, ca, cd} = {o_mem_we, o_mem_size, o_mem_addr, o_mem_wdata};
         n_ack++;
      end
      n_ret += o_retire;
      n_ill += o_illegal;
   end
   task automatic end_of_test;
      $display("errors=%0d n_tests=%0d", errors, n_tests);
      if (errors == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : end_of_test
   task automatic bad(input string msg);
      errors++;
      $display("CHECK FAILED t=%0t %s", $time, msg);
   endtask : bad
   task automatic tick;
      @(posedge i_sys_clk);
      #1;
   endtask : tick
   function automatic int cntv(input int sel);
      cntv = (sel == 0) ? n_ack : (sel == 1) ? n_ret : n_ill;
   endfunction : cntv
   function automatic logic [31:0] sx(input logic [31:0] v, input int k);
      sx = (k == 0) ? {{24{v[7]}}, v[7:0]} : (k == 1) ? {{16{v[15]}}, v[15:0]} : v;
   endfunction : sx
   task automatic wt(input int sel, input int tgt);
      int k;
      k = 0;
      while (((sel < 3) ? cntv(sel) < tgt : !o_insn_ready) && k < 60) begin
         tick();
         k++;
      end
      if (k == 60) begin
         bad("timeout");
         end_of_test();
      end
   endtask : wt
   task automatic put(input logic [15:0] w);
      i_insn_valid = 1'h1;
      i_insn = w;
      wt(3, 0);
      tick();
   endtask : put
   task automatic run(input logic [15:0] w, input int sel);
      int n0;
      n0 = cntv(sel);
      put(w);
      i_insn_valid = 1'h0;
      wt(sel, n0 + 1);
   endtask : run
   task automatic cmp(input logic we, input logic [31:0] a, input int s, input logic [31:0] d);
      logic [31:0] m;
      m = (s == 0) ? 32'hFF : (s == 1) ? 32'hFFFF : 32'hFFFF_FFFF;
      n_tests++;
      if (cw !== we || ca !== a || cs !== 2'(s) || (we && (cd & m) !== (d & m)))
         bad("access differs");
   endtask : cmp
   task automatic xf(input logic [15:0] w, input logic we, input logic [31:0] a, input int s,
                     input logic [31:0] d);
      run(w, 0);
      cmp(we, a, s, d);
   endtask : xf
   task automatic t_basic;
      run(16'hE17F, 1);
      run(16'hE380, 1);
      xf(16'h2132, 1'h1, 32'h7F, 2, 32'hFFFF_FF80);
      xf(16'h2130, 1'h1, 32'h7F, 0, 32'hFFFF_FF80);
      xf(16'h2131, 1'h1, 32'h7F, 1, 32'hFFFF_FF80);
      run(16'h6413, 1);
      xf(16'h2142, 1'h1, 32'h7F, 2, 32'h7F);
   endtask : t_basic
   task automatic t_step;
      logic [31:0] a;
      a = 32'h7F;
      for (int k = 0; k < 3; k++) begin
         a = a - (32'h1 << k);
         xf(16'h2134 + 16'(k), 1'h1, a, k, 32'hFFFF_FF80);
      end
      for (int k = 2; k >= 0; k--) begin
         xf(16'h6514 + 16'(k), 1'h0, a, k, 32'h0);
         a = a + (32'h1 << k);
         xf(16'h2152, 1'h1, a, 2, sx(~(a - (32'h1 << k)), k));
      end
   endtask : t_step
   task automatic t_disp;
      run(16'hE044, 1);
      xf(16'h8012, 1'h1, 32'h81, 0, 32'h44);
      xf(16'h8112, 1'h1, 32'h83, 1, 32'h44);
      xf(16'h1134, 1'h1, 32'h8F, 2, 32'hFFFF_FF80);
      xf(16'h8414, 1'h0, 32'h83, 0, 32'h0);
      xf(16'h2102, 1'h1, 32'h7F, 2, 32'h7C);
      xf(16'h8514, 1'h0, 32'h87, 1, 32'h0);
      xf(16'h2102, 1'h1, 32'h7F, 2, 32'hFFFF_FF78);
      xf(16'h5511, 1'h0, 32'h83, 2, 32'h0);
      xf(16'h2152, 1'h1, 32'h7F, 2, 32'hFFFF_FF7C);
      i_insn_pc = 32'h1000;
      xf(16'h9605, 1'h0, 32'h100A, 1, 32'h0);
      xf(16'h2162, 1'h1, 32'h7F, 2, 32'hFFFF_EFF5);
      xf(16'hD605, 1'h0, 32'h1014, 2, 32'h0);
      xf(16'h2162, 1'h1, 32'h7F, 2, 32'hFFFF_EFEB);
      run(16'hE010, 1);
      xf(16'h0314, 1'h1, 32'hFFFF_FF90, 0, 32'h7F);
   endtask : t_disp
   task automatic t_hazard;
      int n0;
      n0 = n_ack;
      wait_n = 4'h3;
      put(16'h5510);
      put(16'h2152);
      i_insn_valid = 1'h0;
      wt(0, n0 + 2);
      cmp(1'h1, 32'h7F, 2, 32'hFFFF_FF80);
      wait_n = 4'h0;
      i_fetch_busy = 1'h1;
      put(16'h2132);
      i_insn_valid = 1'h0;
      repeat (6) tick();
      n_tests++;
      if (o_mem_req !== 1'h0)
         bad("access during fetch");
      i_fetch_busy = 1'h0;
      wt(0, n0 + 3);
      cmp(1'h1, 32'h7F, 2, 32'hFFFF_FF80);
      i_status_word = 32'h5A5A_0001;
      run(16'h312C, 2);
      n_tests++;
      if (n_ack != n0 + 3 || o_status_word !== 32'h5A5A_0001)
         bad("illegal op effect");
   endtask : t_hazard
   initial begin
      repeat (6) @(posedge i_sys_clk);
      #1;
      i_resetn = 1'h1;
      t_basic();
      t_step();
      t_disp();
      t_hazard();
      end_of_test();
   end
endmodule : data_transfer_insn_decoder_tb
bind data_transfer_insn_decoder data_transfer_insn_decoder_chk data_transfer_insn_decoder_chk_i (
   .i_sys_clk, .i_resetn, .i_insn_valid, .o_insn_ready, .i_fetch_busy, .o_mem_req, .o_mem_we,
   .o_mem_size, .o_mem_addr, .o_mem_wdata, .i_mem_ack, .i_status_word, .o_status_word,
   .o_flag_write, .o_priv_required, .o_retire, .o_illegal);
`default_nettype wire
